/* logic/cmc_pkg.sv */
// Package: constants for the comparator mode and edge-interrupt control register
// Behaviour
// - The top bit of the mode register always reads zero and software writes zero there.
// - Bit six reads zero and whatever is written to it is dropped.
// - Bits three and two read as zero and writes to them have no effect.
// - Bit five enables rising-edge interrupts and bit four enables falling-edge interrupts.
// - An edge interrupt reaches the core only if its edge enable and the group enable are set.
// - The two low bits pick one of four speed/power modes and reset leaves mode two selected.
package cmc_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] CMC_MODE_ADDR = 8'h9D;
	localparam logic [7:0] CMC_MODE_RST = 8'h02;
	localparam int CMC_RSVD_BIT = 7;
	localparam int CMC_UNUSED_BIT = 6;
	localparam int CMC_RISE_BIT = 5;
	localparam int CMC_FALL_BIT = 4;
	localparam int CMC_SEL_HI = 1;
	localparam int CMC_SEL_LO = 0;
	// Only these bits are stored; the rest read zero
	localparam logic [7:0] CMC_WR_MASK = 8'h33;

	typedef enum logic [1:0] {
		CMC_MODE_FAST = 2'h0,
		CMC_MODE_MID1 = 2'h1,
		CMC_MODE_MID2 = 2'h2,
		CMC_MODE_LOWPWR = 2'h3
	} cmc_mode_t;

	function automatic logic [7:0] cmc_pack(input logic rise, input logic fall,
		input cmc_mode_t md);
		logic [7:0] v;
		v = 8'h00;
		v[CMC_RISE_BIT] = rise;
		v[CMC_FALL_BIT] = fall;
		v[CMC_SEL_HI:CMC_SEL_LO] = md;
		return v;
	endfunction : cmc_pack
endpackage : cmc_pkg

/* logic/cmc_edge_if.sv */
// Interface: edge detector to register block
`timescale 1ns/10ps
interface cmc_edge_if;
	logic rise;
	logic fall;
	modport det (output rise, output fall);
	modport ctl (input rise, input fall);
endinterface : cmc_edge_if

/* logic/cmc_edge_det.sv */
// Edge detector on the synchronised comparator output
`timescale 1ns/10ps
module cmc_edge_det
	import cmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic cmp_i,
	cmc_edge_if.det edge_o
);
	logic [1:0] sync_r;
	logic [1:0] sync_nxt;
	logic last_r;
	logic last_nxt;

	always_comb begin
		sync_nxt = {sync_r[0], cmp_i};
		last_nxt = sync_r[1];
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_r <= 2'h0;
			last_r <= 1'b0;
		end else begin
			sync_r <= sync_nxt;
			last_r <= last_nxt;
		end
	end

	// First stage is read only by the second stage
	assign edge_o.rise = sync_r[1] & ~last_r;
	assign edge_o.fall = ~sync_r[1] & last_r;
endmodule : cmc_edge_det

/* logic/cmc_ctl.sv */
// Top: comparator mode register and edge interrupt pending logic
`timescale 1ns/10ps
module cmc_ctl
	import cmc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic cmp_out_i,
	input wire logic cmp_irq_group_en_i,
	input wire logic rise_clr_i,
	input wire logic fall_clr_i,
	output logic [7:0] sfr_rdata_o,
	output logic [1:0] cmp_mode_o,
	output logic rise_pend_o,
	output logic fall_pend_o,
	output logic cmp_irq_o
);
	// ****************************************
	// Reset release
	// ****************************************
	logic [1:0] rst_sync_r;
	logic rst_n;
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// ****************************************
	// Register
	// ****************************************
	logic cmp_rise_irq_en_r, cmp_rise_irq_en_nxt;
	logic cmp_fall_irq_en_r, cmp_fall_irq_en_nxt;
	cmc_mode_t mode_r, mode_nxt;
	logic rise_pend_r, rise_pend_nxt;
	logic fall_pend_r, fall_pend_nxt;
	logic irq_r, irq_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic hit;

	cmc_edge_if eif ();
	cmc_edge_det u_det (
		.clk_i(core_clk_i),
		.rst_n_i(rst_n),
		.cmp_i(cmp_out_i),
		.edge_o(eif)
	);

	always_comb begin
		hit = (sfr_addr_i == CMC_MODE_ADDR);
		cmp_rise_irq_en_nxt = cmp_rise_irq_en_r;
		cmp_fall_irq_en_nxt = cmp_fall_irq_en_r;
		mode_nxt = mode_r;
		if (sfr_wr_i && hit) begin
			// Bits 7, 6, 3, 2 are not stored at all
			cmp_rise_irq_en_nxt = sfr_wdata_i[CMC_RISE_BIT];
			cmp_fall_irq_en_nxt = sfr_wdata_i[CMC_FALL_BIT];
			mode_nxt = cmc_mode_t'(sfr_wdata_i[CMC_SEL_HI:CMC_SEL_LO]);
		end
		// Set wins over clear so no edge is lost
		rise_pend_nxt = (rise_pend_r & ~rise_clr_i) | (eif.rise & cmp_rise_irq_en_r);
		fall_pend_nxt = (fall_pend_r & ~fall_clr_i) | (eif.fall & cmp_fall_irq_en_r);
		irq_nxt = cmp_irq_group_en_i & (rise_pend_nxt | fall_pend_nxt);
		rdata_nxt = rdata_r;
		if (sfr_rd_i && hit) begin
			rdata_nxt = cmc_pack(cmp_rise_irq_en_r, cmp_fall_irq_en_r, mode_r);
		end else if (sfr_rd_i) begin
			rdata_nxt = 8'h00;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cmp_rise_irq_en_r <= CMC_MODE_RST[CMC_RISE_BIT];
			cmp_fall_irq_en_r <= CMC_MODE_RST[CMC_FALL_BIT];
			mode_r <= cmc_mode_t'(CMC_MODE_RST[CMC_SEL_HI:CMC_SEL_LO]);
			rise_pend_r <= 1'b0;
			fall_pend_r <= 1'b0;
			irq_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			cmp_rise_irq_en_r <= cmp_rise_irq_en_nxt;
			cmp_fall_irq_en_r <= cmp_fall_irq_en_nxt;
			mode_r <= mode_nxt;
			rise_pend_r <= rise_pend_nxt;
			fall_pend_r <= fall_pend_nxt;
			irq_r <= irq_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign sfr_rdata_o = rdata_r;
	assign cmp_mode_o = mode_r;
	assign rise_pend_o = rise_pend_r;
	assign fall_pend_o = fall_pend_r;
	assign cmp_irq_o = irq_r;

	// ****************************************
	// Checks
	// ****************************************
	a_reserved_reads_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		$past(sfr_rd_i) |-> (sfr_rdata_o[CMC_RSVD_BIT] == 1'b0))
		else $error("reserved bit read non-zero");
	a_unused_reads_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		(sfr_rdata_o & ~CMC_WR_MASK) == 8'h00)
		else $error("unused bits read non-zero");
	a_write_mid_ignored: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		sfr_rd_i && hit |=> sfr_rdata_o[3:2] == 2'h0)
		else $error("bits 3:2 not zero");
	a_rise_en_write: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		sfr_wr_i && hit |=> cmp_rise_irq_en_r == $past(sfr_wdata_i[CMC_RISE_BIT]))
		else $error("rise enable not written");
	a_fall_en_write: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		sfr_wr_i && hit |=> cmp_fall_irq_en_r == $past(sfr_wdata_i[CMC_FALL_BIT]))
		else $error("fall enable not written");
	a_irq_needs_group: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		cmp_irq_o |-> $past(cmp_irq_group_en_i) && (rise_pend_o || fall_pend_o))
		else $error("irq without both enables");
	a_mode_write: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		sfr_wr_i && hit |=> cmp_mode_o == $past(sfr_wdata_i[1:0]))
		else $error("mode not written");
	a_rise_pend_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		$rose(rise_pend_o) |-> $past(cmp_rise_irq_en_r) && $past(eif.rise))
		else $error("rise pend without enabled edge");
	a_set_beats_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		eif.fall && cmp_fall_irq_en_r |=> fall_pend_o)
		else $error("fall edge lost");
endmodule : cmc_ctl

/* dv/cmc_cpu.sv */
// Core-side model: register strobes and comparator level
`timescale 1ns/10ps
module cmc_cpu (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic cmp_o
);
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
		cmp_o = 1'b0;
	end
	// Released bus shows the inverse so stale values cannot pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		wr_o = 1'b1;
		addr_o = a;
		wdata_o = d & 8'h7F;
		@(negedge clk_i);
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~wdata_o;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		rd_o = 1'b1;
		addr_o = a;
		@(negedge clk_i);
		rd_o = 1'b0;
		addr_o = ~a;
		d = rdata_i;
	endtask : rd
	// Output settles through the sync chain before the caller checks
	task automatic cmp(input logic v);
		@(negedge clk_i);
		cmp_o = v;
		repeat (4) @(negedge clk_i);
	endtask : cmp
endmodule : cmc_cpu

/* dv/cmc_ctl_tb.sv */
// Testbench for the comparator mode register
`timescale 1ns/10ps
module cmc_ctl_tb
	import cmc_pkg::*;
;
	logic clk = 1'b0;
	logic rstn, wr, rd, cmp, gen, rclr, fclr, rp, fp, irq;
	logic [7:0] addr, wd, rdat, d;
	logic [1:0] mode;
	int n_mismatch = 0;
	int cmp_count = 0;
	always #50 clk = ~clk;
	cmc_cpu u_cmc_cpu (.clk_i(clk), .rdata_i(rdat), .wr_o(wr), .rd_o(rd),
		.addr_o(addr), .wdata_o(wd), .cmp_o(cmp));
	cmc_ctl u_cmc_ctl (.core_clk_i(clk), .rstn_i(rstn), .sfr_wr_i(wr), .sfr_rd_i(rd),
		.sfr_addr_i(addr), .sfr_wdata_i(wd), .cmp_out_i(cmp), .cmp_irq_group_en_i(gen),
		.rise_clr_i(rclr), .fall_clr_i(fclr), .sfr_rdata_o(rdat), .cmp_mode_o(mode),
		.rise_pend_o(rp), .fall_pend_o(fp), .cmp_irq_o(irq));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic end_sim();
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_sim
	initial begin
		rstn = 1'b0;
		gen = 1'b0;
		rclr = 1'b0;
		fclr = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		u_cmc_cpu.rd(CMC_MODE_ADDR, d);
		chk("reset", CMC_MODE_RST, d);
		u_cmc_cpu.wr(CMC_MODE_ADDR, 8'hFF);
		u_cmc_cpu.rd(CMC_MODE_ADDR, d);
		chk("unused", 8'h33, d);
		chk("rsvd", 8'h00, {d[7], 7'h00});
		chk("low", 8'h00, {6'h00, d[3:2]});
		u_cmc_cpu.rd(8'h9C, d);
		chk("unmapped", 8'h00, d);
		for (int i = 0; i < 4; i++) begin
			u_cmc_cpu.wr(CMC_MODE_ADDR, 8'(i));
			chk("mode", 8'(i), {6'h00, mode});
		end
		u_cmc_cpu.wr(CMC_MODE_ADDR, 8'h20);
		gen = 1'b1;
		u_cmc_cpu.cmp(1'b1);
		chk("rise", 8'h01, {7'h00, rp});
		chk("irq", 8'h01, {7'h00, irq});
		u_cmc_cpu.cmp(1'b0);
		chk("fall off", 8'h00, {7'h00, fp});
		rclr = 1'b1;
		@(negedge clk);
		rclr = 1'b0;
		@(negedge clk);
		chk("irq clr", 8'h00, {7'h00, irq});
		u_cmc_cpu.wr(CMC_MODE_ADDR, 8'h10);
		gen = 1'b0;
		u_cmc_cpu.cmp(1'b1);
		chk("rise off", 8'h00, {7'h00, rp});
		u_cmc_cpu.cmp(1'b0);
		chk("fall", 8'h01, {7'h00, fp});
		chk("gated", 8'h00, {7'h00, irq});
		gen = 1'b1;
		repeat (2) @(negedge clk);
		chk("ungated", 8'h01, {7'h00, irq});
		end_sim();
	end
	initial begin
		#200000;
		n_mismatch++;
		end_sim();
	end
endmodule : cmc_ctl_tb
